// ---- common/prc_pkg.sv ----
// prc_pkg: offsets, field positions, reset values and step constants for
// the playback range compressor control block.
// assumes one system clock and a word-clock strobe from the same domain.
package prc_pkg;
  // register offsets
  localparam logic [7:0] PRC_OFS_CTL = 8'h44;
  localparam logic [7:0] PRC_OFS_HOLD = 8'h45;
  localparam logic [7:0] PRC_OFS_RATE = 8'h46;
  // writable bit masks, reserved bits are stored as zero
  localparam logic [7:0] PRC_CTL_MASK = 8'h7f;
  localparam logic [7:0] PRC_HOLD_MASK = 8'h78;
  localparam logic [7:0] PRC_RATE_MASK = 8'hff;
  // reset values
  localparam logic [7:0] PRC_CTL_RST = 8'h0f;
  localparam logic [7:0] PRC_HOLD_RST = 8'h38;
  localparam logic [7:0] PRC_RATE_RST = 8'h00;
  // field positions
  localparam int PRC_EN_L_BIT = 6;
  localparam int PRC_EN_R_BIT = 5;
  localparam int PRC_THR_LSB = 2;
  localparam int PRC_HYST_LSB = 0;
  localparam int PRC_HOLD_LSB = 3;
  localparam int PRC_ATK_LSB = 4;
  localparam int PRC_DCY_LSB = 0;
  // threshold: 3 dB per code step, code 0 is -3 dB
  localparam logic [7:0] PRC_THR_STEP_DB = 8'h03;
  // hold: code 1 gives the base, codes up to the knee double it
  localparam int PRC_HOLD_BASE_WC = 32;
  localparam logic [3:0] PRC_HOLD_KNEE = 4'hb;
  localparam logic [3:0] PRC_HOLD_LONG_OFS = 4'ha;
  localparam int PRC_HOLD_LONG_SHIFT = 10;
  // rate steps: full step value at code 0, halved per code
  localparam logic [15:0] PRC_STEP_FULL = 16'h8000;
endpackage

// ---- verilog/prc_top.sv ----
// prc_top: control logic of the playback range compressor, register port,
// per-channel threshold/hysteresis tracking and hold timing.
// assumes the register port, the word strobe and the levels are driven by
// logic on clk_i; the volume stage applies the step sizes it is given.
//
// Contract
// RULE1 - left compression acts only while the left enable bit is one, reset zero.
// RULE2 - right compression acts only while the right enable bit is one, reset zero.
// RULE3 - the threshold code picks -3 dB at 000 to -24 dB at 111 in 3 dB steps, reset 011.
// RULE4 - the hysteresis code picks 0 to 3 dB, reset 11.
// RULE5 - hold code 0000 disables hold, 0001 gives 32 word clocks doubling to 512 at 0101.
// RULE6 - hold codes 1110 and 1111 give four and five times 32768 word clocks.
// RULE7 - software writes only reset values into the reserved bits.
// RULE8 - hold codes 0110 to 1011 keep doubling to 32768, 1100 and 1101 give 2x and 3x 32768.
// RULE9 - the attack code gives 4 dB per word clock at 0000, halving per code.
// RULE10 - the decay code gives 1.5625e-2 dB per word clock at 0000, halving per code.
// RULE11 - while compression is enabled the volume controls act independently.
`timescale 1ns/1ps
module prc_top #(
  parameter int HOLD_BASE = prc_pkg::PRC_HOLD_BASE_WC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // word clock and channel levels in dB below full scale, index 0 left
  input wire logic wclk_stb_i,
  input wire logic [1:0][7:0] level_db_i,
  // per-channel control to the volume stage
  output logic [1:0] comp_active_o,
  output logic [1:0] attack_o,
  output logic [1:0] decay_o,
  // decoded parameters
  output logic [7:0] thr_db_o,
  output logic [1:0] hyst_db_o,
  output logic [17:0] hold_len_o,
  output logic [15:0] attack_step_o,
  output logic [15:0] decay_step_o,
  output logic link_force_o
);

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] hold;
    logic [7:0] rate;
    logic [7:0] rdata;
    logic rvalid;
    logic [1:0] active;
    logic [1:0][17:0] hold_cnt;
    logic [1:0] attack;
    logic [1:0] decay;
    logic [7:0] thr_db;
    logic [1:0] hyst_db;
    logic [17:0] hold_len;
    logic [15:0] atk_step;
    logic [15:0] dcy_step;
    logic link_force;
  } prc_state_t;

  prc_state_t st_reg;
  prc_state_t st_next;

  // hold length in word clocks for a hold code
  function automatic logic [17:0] prc_hold_len(input logic [3:0] code);
    logic [17:0] base;
    base = 18'(HOLD_BASE);
    if (code == 4'h0) begin
      prc_hold_len = 18'h00000; // [RULE5]
    end else if (code <= prc_pkg::PRC_HOLD_KNEE) begin
      prc_hold_len = base << (code - 4'h1); // [RULE5] [RULE8]
    end else begin
      // 2x..5x of the 32768 point for codes 1100..1111
      prc_hold_len = 18'((base << prc_pkg::PRC_HOLD_LONG_SHIFT) *
                         {14'h0000, code - prc_pkg::PRC_HOLD_LONG_OFS}); // [RULE6] [RULE8]
    end
  endfunction

  logic [2:0] thr_code;
  logic [3:0] hold_code;
  logic [7:0] thr_db;
  logic [7:0] rel_db;
  logic [1:0] en;

  // register port, decode and per-channel tracking
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.attack = 2'b00;
    st_next.decay = 2'b00;
    // reserved bits are masked so they always read back as their reset zero
    if (reg_wr_i) begin
      case (reg_addr_i)
        prc_pkg::PRC_OFS_CTL: st_next.ctl = reg_wdata_i & prc_pkg::PRC_CTL_MASK; // [RULE7]
        prc_pkg::PRC_OFS_HOLD: st_next.hold = reg_wdata_i & prc_pkg::PRC_HOLD_MASK; // [RULE7]
        prc_pkg::PRC_OFS_RATE: st_next.rate = reg_wdata_i & prc_pkg::PRC_RATE_MASK;
        default: st_next.ctl = st_reg.ctl;
      endcase
    end
    if (reg_rd_i) begin
      st_next.rvalid = 1'b1;
      case (reg_addr_i)
        prc_pkg::PRC_OFS_CTL: st_next.rdata = st_reg.ctl;
        prc_pkg::PRC_OFS_HOLD: st_next.rdata = st_reg.hold;
        prc_pkg::PRC_OFS_RATE: st_next.rdata = st_reg.rate;
        default: st_next.rdata = 8'h00;
      endcase
    end
    // decoded values follow the new register contents in the same edge
    thr_code = st_next.ctl[prc_pkg::PRC_THR_LSB +: 3];
    hold_code = st_next.hold[prc_pkg::PRC_HOLD_LSB +: 4];
    thr_db = 8'(({5'h00, thr_code} + 8'h01) * prc_pkg::PRC_THR_STEP_DB); // [RULE3]
    st_next.thr_db = thr_db;
    st_next.hyst_db = st_next.ctl[prc_pkg::PRC_HYST_LSB +: 2]; // [RULE4]
    rel_db = thr_db + {6'h00, st_next.hyst_db};
    st_next.hold_len = prc_hold_len(hold_code);
    st_next.atk_step = prc_pkg::PRC_STEP_FULL >>
                       st_next.rate[prc_pkg::PRC_ATK_LSB +: 4]; // [RULE9]
    st_next.dcy_step = prc_pkg::PRC_STEP_FULL >>
                       st_next.rate[prc_pkg::PRC_DCY_LSB +: 4]; // [RULE10]
    en[0] = st_reg.ctl[prc_pkg::PRC_EN_L_BIT];
    en[1] = st_reg.ctl[prc_pkg::PRC_EN_R_BIT];
    // any enabled channel forces independent volume in the volume stage
    st_next.link_force = st_next.ctl[prc_pkg::PRC_EN_L_BIT] |
                         st_next.ctl[prc_pkg::PRC_EN_R_BIT]; // [RULE11]
    // the hysteresis band between threshold and release keeps the state,
    // so a level near the threshold does not chatter attack and decay
    for (int ch = 0; ch < 2; ch++) begin
      if (!en[ch]) begin
        st_next.active[ch] = 1'b0; // [RULE1] [RULE2]
        st_next.hold_cnt[ch] = 18'h00000;
      end else if (wclk_stb_i) begin
        if (level_db_i[ch] < st_reg.thr_db) begin
          st_next.active[ch] = 1'b1;
        end else if (level_db_i[ch] >= rel_db) begin
          st_next.active[ch] = 1'b0;
        end
        if (st_next.active[ch]) begin
          st_next.attack[ch] = 1'b1; // [RULE1] [RULE2]
          st_next.hold_cnt[ch] = st_reg.hold_len;
        end else if (st_reg.hold_cnt[ch] != 18'h00000) begin
          st_next.hold_cnt[ch] = st_reg.hold_cnt[ch] - 18'h00001; // [RULE5]
        end else begin
          st_next.decay[ch] = 1'b1;
        end
      end
    end
  end

  // one register for all state, constants only under reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.ctl <= prc_pkg::PRC_CTL_RST; // [RULE1] [RULE2] [RULE3] [RULE4]
      st_reg.hold <= prc_pkg::PRC_HOLD_RST;
      st_reg.rate <= prc_pkg::PRC_RATE_RST;
      st_reg.thr_db <= 8'h0c;
      st_reg.hyst_db <= 2'h3;
      st_reg.hold_len <= 18'(HOLD_BASE) << 6;
      st_reg.atk_step <= prc_pkg::PRC_STEP_FULL;
      st_reg.dcy_step <= prc_pkg::PRC_STEP_FULL;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_o = st_reg.rdata;
  assign reg_rvalid_o = st_reg.rvalid;
  assign comp_active_o = st_reg.active;
  assign attack_o = st_reg.attack;
  assign decay_o = st_reg.decay;
  assign thr_db_o = st_reg.thr_db;
  assign hyst_db_o = st_reg.hyst_db;
  assign hold_len_o = st_reg.hold_len;
  assign attack_step_o = st_reg.atk_step;
  assign decay_step_o = st_reg.dcy_step;
  assign link_force_o = st_reg.link_force;

  // checks on the decoded values and channel behaviour
  property p_left_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      !st_reg.ctl[prc_pkg::PRC_EN_L_BIT] |=> !attack_o[0] && !decay_o[0] && !comp_active_o[0];
  endproperty
  a_left_off: assert property (p_left_off) else $error("left acts while disabled"); // [RULE1]

  property p_right_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      !st_reg.ctl[prc_pkg::PRC_EN_R_BIT] |=> !attack_o[1] && !decay_o[1] && !comp_active_o[1];
  endproperty
  a_right_off: assert property (p_right_off) else $error("right acts while disabled"); // [RULE2]

  property p_thr;
    @(posedge clk_i) disable iff (!rst_n_i)
      thr_db_o == 8'(3 * (st_reg.ctl[4:2] + 1)) && thr_db_o >= 8'h03 && thr_db_o <= 8'h18;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold decode wrong"); // [RULE3]

  property p_hyst;
    @(posedge clk_i) disable iff (!rst_n_i)
      reg_wr_i && reg_addr_i == prc_pkg::PRC_OFS_CTL |=> hyst_db_o == $past(reg_wdata_i[1:0]);
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis not taken"); // [RULE4]

  property p_hold_short;
    @(posedge clk_i) disable iff (!rst_n_i)
      (st_reg.hold[6:3] == 4'h0 |-> hold_len_o == 18'h0) and
      (st_reg.hold[6:3] == 4'h5 |-> hold_len_o == 18'(HOLD_BASE * 16));
  endproperty
  a_hold_short: assert property (p_hold_short) else $error("short hold decode wrong"); // [RULE5]

  property p_hold_long;
    @(posedge clk_i) disable iff (!rst_n_i)
      st_reg.hold[6:3] == 4'hf |-> hold_len_o == 18'(HOLD_BASE * 5 * 1024);
  endproperty
  a_hold_long: assert property (p_hold_long) else $error("long hold decode wrong"); // [RULE6]

  property p_hold_mid;
    @(posedge clk_i) disable iff (!rst_n_i)
      (st_reg.hold[6:3] == 4'hb |-> hold_len_o == 18'(HOLD_BASE * 1024)) and
      (st_reg.hold[6:3] == 4'hc |-> hold_len_o == 18'(HOLD_BASE * 2048));
  endproperty
  a_hold_mid: assert property (p_hold_mid) else $error("mid hold decode wrong"); // [RULE8]

  property p_attack;
    @(posedge clk_i) disable iff (!rst_n_i)
      attack_step_o == (16'h8000 >> st_reg.rate[7:4]);
  endproperty
  a_attack: assert property (p_attack) else $error("attack step wrong"); // [RULE9]

  property p_decay;
    @(posedge clk_i) disable iff (!rst_n_i)
      decay_step_o == (16'h8000 >> st_reg.rate[3:0]);
  endproperty
  a_decay: assert property (p_decay) else $error("decay step wrong"); // [RULE10]

  property p_link;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(st_reg.ctl[6] | st_reg.ctl[5]) |-> link_force_o;
  endproperty
  a_link: assert property (p_link) else $error("volume link not forced"); // [RULE11]

  c_attack_l: cover property (@(posedge clk_i) disable iff (!rst_n_i) attack_o[0]);
  c_decay_r: cover property (@(posedge clk_i) disable iff (!rst_n_i) decay_o[1]);
  c_release: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(comp_active_o[0]));
endmodule

// ---- bench/prc_src.sv ----
// prc_src: model of the upstream playback path, word strobe and levels.
// assumes the bench drives run_i and level_i at the falling edge of clk_i.
`timescale 1ns/1ps
module prc_src (
  // clock and control from the bench
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [1:0][7:0] level_i,
  // towards the compressor
  output logic wclk_stb_o,
  output logic [1:0][7:0] level_db_o
);
  logic [1:0] cnt_reg;
  // one word every four clocks while running, so n words take 4n clocks
  always_ff @(posedge clk_i) begin
    cnt_reg <= run_i ? cnt_reg + 2'h1 : 2'h0;
  end
  assign wclk_stb_o = run_i && (cnt_reg == 2'h3);
  assign level_db_o = level_i;
endmodule

// ---- bench/prc_top_tb.sv ----
// prc_top_tb: self-checking bench for the compressor control block.
// assumes prc_src feeds the word strobe; hold base is shrunk to 2.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module prc_top_tb;
  localparam int HB = 2;
  logic clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, run = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, thr_db_o, rd_v;
  logic [1:0][7:0] lvl = '0, level_db_i;
  logic [1:0] comp_active_o, attack_o, decay_o, hyst_db_o;
  logic [17:0] hold_len_o;
  logic [15:0] attack_step_o, decay_step_o;
  logic reg_rvalid_o, wclk_stb_i, link_force_o;
  int fails = 0, n_compared = 0, n_att[2], n_dcy[2];
  always #20 clk_i = ~clk_i;
  prc_src i_prc_src (.clk_i(clk_i), .run_i(run), .level_i(lvl), .wclk_stb_o(wclk_stb_i),
    .level_db_o(level_db_i));
  prc_top #(.HOLD_BASE(HB)) i_prc_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .wclk_stb_i(wclk_stb_i), .level_db_i(level_db_i), .comp_active_o(comp_active_o),
    .attack_o(attack_o), .decay_o(decay_o), .thr_db_o(thr_db_o), .hyst_db_o(hyst_db_o),
    .hold_len_o(hold_len_o), .attack_step_o(attack_step_o), .decay_step_o(decay_step_o),
    .link_force_o(link_force_o));
  // pulse counters per channel
  always @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      n_att[c] += attack_o[c];
      n_dcy[c] += decay_o[c];
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
    @(negedge clk_i) reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i) {reg_addr_i, reg_rd_i} = {a, 1'b1};
    @(negedge clk_i) reg_rd_i = 1'b0;
    `CHK(reg_rvalid_o, 1'b1)
    `CHK(reg_rdata_o, exp)
  endtask
  // n words, then counters are read after the last pulse has landed
  task automatic words(input int n);
    n_att = '{0, 0};
    n_dcy = '{0, 0};
    @(negedge clk_i) run = 1'b1;
    repeat (4 * n) @(negedge clk_i);
    run = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  function automatic logic [17:0] hold_exp(input int c);
    if (c == 0) return 18'h0;
    if (c < 12) return 18'(HB << (c - 1));
    return 18'((c - 10) * (HB << 10));
  endfunction
  task automatic t_reset();
    rd(8'h44, 8'h0f);
    rd(8'h45, 8'h38);
    rd(8'h46, 8'h00);
    rd(8'h47, 8'h00);
    `CHK(thr_db_o, 8'h0c)
    `CHK(hyst_db_o, 2'h3)
    `CHK(hold_len_o, 18'(HB << 6))
    $display("test reset done");
  endtask
  task automatic t_fields();
    for (int t = 0; t < 8; t++) begin
      wr(8'h44, 8'((t << 2) | (t % 4)));
      `CHK(thr_db_o, 8'(3 * (t + 1)))
      `CHK(hyst_db_o, 2'(t % 4))
    end
    for (int c = 0; c < 16; c++) begin
      wr(8'h45, 8'(c << 3));
      `CHK(hold_len_o, hold_exp(c))
      wr(8'h46, 8'((c << 4) | (15 - c)));
      `CHK(attack_step_o, 16'h8000 >> c)
      `CHK(decay_step_o, 16'h8000 >> (15 - c))
    end
    $display("test fields done");
  endtask
  // left enabled alone at -3 dB, no hysteresis, right idle; then right enabled alone, left idle
  task automatic t_hold(input int code, input int n_exp);
    wr(8'h45, 8'(code << 3));
    wr(8'h44, 8'h40);
    `CHK(link_force_o, 1'b1)
    lvl = 16'h0000;
    words(2);
    `CHK(comp_active_o, 2'b01)
    `CHK(n_att[0], 2)
    `CHK(n_att[1], 0)
    lvl = 16'h0a0a;
    words(6);
    `CHK(comp_active_o, 2'b00)
    `CHK(n_dcy[0], n_exp)
    wr(8'h44, 8'h20);
    lvl = 16'h0000;
    words(1);
    `CHK(comp_active_o, 2'b10)
    `CHK(n_att[1], 1)
    `CHK(n_att[0], 0)
    // right released: the hold eats the first words, the rest decay
    lvl = 16'h0a0a;
    words(3);
    `CHK(comp_active_o, 2'b00)
    `CHK(n_dcy[1], n_exp - 3)
    `CHK(n_dcy[0], 0)
    wr(8'h44, 8'h00);
    `CHK(link_force_o, 1'b0)
    $display("test hold done");
  endtask
  // left at -3 dB with 3 dB hysteresis: levels inside the band keep the state
  task automatic t_hyst();
    wr(8'h45, 8'h00);
    wr(8'h44, 8'h43);
    lvl = 16'h0000;
    words(1);
    `CHK(comp_active_o, 2'b01)
    lvl = 16'h0004;
    words(2);
    `CHK(comp_active_o, 2'b01)
    `CHK(n_att[0], 2)
    lvl = 16'h0006;
    words(1);
    `CHK(comp_active_o, 2'b00)
    `CHK(n_dcy[0], 1)
    lvl = 16'h0004;
    words(2);
    `CHK(comp_active_o, 2'b00)
    `CHK(n_att[0], 0)
    `CHK(n_dcy[0], 2)
    wr(8'h44, 8'h00);
    $display("test hysteresis done");
  endtask
  // reset pulled in after register writes, with run low and no words, must bring every register back to its reset value
  task automatic t_mid_reset();
    wr(8'h46, 8'h5a);
    wr(8'h44, 8'h63);
    @(negedge clk_i) rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    `CHK(comp_active_o, 2'b00)
    `CHK(link_force_o, 1'b0)
    rst_n_i = 1'b1;
    t_reset();
    $display("test mid reset done");
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_fields();
    t_hold(1, 4);
    t_hold(0, 6);
    t_hyst();
    t_mid_reset();
    give_verdict();
  end
  initial begin
    #(40 * 5000);
    fails++;
    give_verdict();
  end
endmodule
